// *** dv/camera_ctrl_model.sv ***
// camera controller model that drives every sensor control pin
// assumes ref_clk is the bench clock; pointer, row and hold pin levels change at its falling edge, serial pins on fixed delays
`timescale 1ns/1ns
module camera_ctrl_model
(
    input  wire logic ref_clk,
    output logic      serial_clock,
    output logic      serial_data,
    output logic      chip_select,
    output logic      reset_pointer_clock,
    output logic      reset_pointer_sync_n,
    output logic      reset_pointer_activate,
    output logic      readout_pointer_clock,
    output logic      readout_pointer_sync_n,
    output logic      readout_pointer_activate,
    output logic      column_clock,
    output logic      column_sync_n,
    output logic      switch_clock,
    output logic      switch_sync_n,
    output logic      row_select,
    output logic      row_reset,
    output logic      reset_level_hold,
    output logic      signal_level_hold,
    output logic      row_init_pulse
);
    logic [2:0] clk_q;
    logic [2:0] sync_n_q;

    assign reset_pointer_clock    = clk_q[0];
    assign reset_pointer_sync_n   = sync_n_q[0];
    assign readout_pointer_clock  = clk_q[1];
    assign readout_pointer_sync_n = sync_n_q[1];
    assign column_clock           = clk_q[2];
    assign column_sync_n          = sync_n_q[2];
    // switchboard wired to the readout pins so both stay identical
    assign switch_clock           = clk_q[1];
    assign switch_sync_n          = sync_n_q[1];

    initial
    begin
        clk_q = 3'h0;
        sync_n_q = 3'h7;
        {serial_clock, serial_data, chip_select} = 3'h0;
        {reset_pointer_activate, readout_pointer_activate} = 2'h0;
        {row_select, row_reset} = 2'h0;
        {reset_level_hold, signal_level_hold, row_init_pulse} = 3'h0;
    end

    // one pointer clock pulse, sync set up 40 ns ahead, 40 ns per phase
    task automatic step(input int idx, input logic sync_n);
        @(negedge ref_clk);
        sync_n_q[idx] = sync_n;
        repeat (4) @(negedge ref_clk);
        clk_q[idx] = 1'b1;
        repeat (4) @(negedge ref_clk);
        clk_q[idx] = 1'b0;
        sync_n_q[idx] = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask

    // act 1 = reset pointer, 2 = readout pointer; never both at once
    task automatic set_drive(input logic [1:0] act, input logic sel, input logic rst);
        @(negedge ref_clk);
        reset_pointer_activate = act == 2'h1;
        readout_pointer_activate = act == 2'h2;
        row_select = sel;
        row_reset = rst;
    endtask

    task automatic set_holds(input logic [2:0] v);
        @(negedge ref_clk);
        {reset_level_hold, signal_level_hold, row_init_pulse} = v;
    endtask

    // serial clock only runs inside a frame, 125 ns period
    task automatic send_bits(input logic [31:0] w, input int n);
        chip_select = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            serial_data = w[i];
            #62;
            serial_clock = 1'b1;
            #63;
            serial_clock = 1'b0;
        end
        // released data line must not look like a stale bit
        serial_data = ~serial_data;
        #100;
        chip_select = 1'b1;
        #200;
        // chip select idles low, the level the edge detector assumes at reset
        chip_select = 1'b0;
    endtask
endmodule

// *** dv/image_sensor_pin_control_test.sv ***
// self-checking bench for the sensor pin control logic
// assumes the controller model drives all pins; the bench drives only sys_rst and otherwise observes
`timescale 1ns/1ns
module image_sensor_pin_control_test
    import sensor_pkg::*;
;
    logic             ref_clk;
    logic             sys_rst;
    logic             serial_clock, serial_data, chip_select;
    logic             rp_clk, rp_sync_n, rp_act, ro_clk, ro_sync_n, ro_act;
    logic             column_clock, column_sync_n, switch_clock, switch_sync_n;
    logic             row_select, row_reset, rst_hold, sig_hold, row_init;
    logic [ROW_W-1:0] reset_row_q, readout_row_q, drive_row_q;
    logic             row_select_drive_q, row_reset_drive_q, crossbar_q;
    logic [COL_W-1:0] column_pos_q;
    logic             reset_hold_q, signal_hold_q, row_init_q, config_valid_q;
    logic [CFG_W-1:0] config_q;
    int               mismatches;
    int               check_count;

    camera_ctrl_model ctrl (
        .ref_clk(ref_clk), .serial_clock(serial_clock), .serial_data(serial_data),
        .chip_select(chip_select), .reset_pointer_clock(rp_clk),
        .reset_pointer_sync_n(rp_sync_n), .reset_pointer_activate(rp_act),
        .readout_pointer_clock(ro_clk), .readout_pointer_sync_n(ro_sync_n),
        .readout_pointer_activate(ro_act), .column_clock(column_clock),
        .column_sync_n(column_sync_n), .switch_clock(switch_clock),
        .switch_sync_n(switch_sync_n), .row_select(row_select), .row_reset(row_reset),
        .reset_level_hold(rst_hold), .signal_level_hold(sig_hold),
        .row_init_pulse(row_init)
    );

    sensor_pin_control uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clock(serial_clock),
        .serial_data(serial_data), .chip_select(chip_select),
        .reset_pointer_clock(rp_clk), .reset_pointer_sync_n(rp_sync_n),
        .reset_pointer_activate(rp_act), .readout_pointer_clock(ro_clk),
        .readout_pointer_sync_n(ro_sync_n), .readout_pointer_activate(ro_act),
        .column_clock(column_clock), .column_sync_n(column_sync_n),
        .switch_clock(switch_clock), .switch_sync_n(switch_sync_n),
        .row_select(row_select), .row_reset(row_reset), .reset_level_hold(rst_hold),
        .signal_level_hold(sig_hold), .row_init_pulse(row_init),
        .reset_row_q(reset_row_q), .readout_row_q(readout_row_q),
        .drive_row_q(drive_row_q), .row_select_drive_q(row_select_drive_q),
        .row_reset_drive_q(row_reset_drive_q), .column_pos_q(column_pos_q),
        .crossbar_q(crossbar_q), .reset_hold_q(reset_hold_q),
        .signal_hold_q(signal_hold_q), .row_init_q(row_init_q),
        .config_q(config_q), .config_valid_q(config_valid_q)
    );

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] ptr(input int idx);
        if (idx == 0)
            return {3'h0, reset_row_q};
        if (idx == 1)
            return {3'h0, readout_row_q};
        return {4'h0, column_pos_q};
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        sys_rst = 1'b1;
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(ptr(0), 16'h0001);
        check(ptr(1), 16'h0001);
        check(ptr(2), 16'h0001);
        check(config_valid_q, 1'b0);
        check(crossbar_q, 1'b0);
        // pin levels reach the edge detector later; no false load may follow
        repeat (4) @(negedge ref_clk);
        check(config_valid_q, 1'b0);
        $display("test reset done");
    endtask

    // two steps, sync, then one step after the sync
    task automatic test_pointers();
        for (int p = 0; p < 3; p++)
        begin
            ctrl.step(p, 1'b1);
            ctrl.step(p, 1'b1);
            check(ptr(p), 16'h0003);
            ctrl.step(p, 1'b0);
            check(ptr(p), 16'h0001);
            ctrl.step(p, 1'b1);
            check(ptr(p), 16'h0002);
            ctrl.step(p, 1'b0);
        end
        $display("test pointers done");
    endtask

    task automatic test_rows();
        ctrl.step(0, 1'b1);
        ctrl.step(0, 1'b1);
        ctrl.set_drive(2'h1, 1'b1, 1'b0);
        repeat (6) @(negedge ref_clk);
        check(drive_row_q, 16'h0003);
        check(row_select_drive_q, 1'b1);
        check(row_reset_drive_q, 1'b0);
        ctrl.set_drive(2'h2, 1'b0, 1'b1);
        repeat (6) @(negedge ref_clk);
        check(drive_row_q, 16'h0001);
        check(row_select_drive_q, 1'b0);
        check(row_reset_drive_q, 1'b1);
        // no pointer active: pins alone drive nothing
        ctrl.set_drive(2'h0, 1'b1, 1'b1);
        repeat (6) @(negedge ref_clk);
        check(row_select_drive_q, 1'b0);
        check(row_reset_drive_q, 1'b0);
        ctrl.set_drive(2'h0, 1'b0, 1'b0);
        $display("test rows done");
    endtask

    task automatic test_holds();
        ctrl.set_holds(3'h5);
        repeat (6) @(negedge ref_clk);
        check({reset_hold_q, signal_hold_q, row_init_q}, 3'h5);
        ctrl.set_holds(3'h2);
        repeat (6) @(negedge ref_clk);
        check({reset_hold_q, signal_hold_q, row_init_q}, 3'h2);
        $display("test holds done");
    endtask

    // second word is 20 bits long, only the last 16 count
    task automatic test_serial();
        ctrl.send_bits(32'h0000_3a5c, 16);
        check(config_q, 16'h3a5c);
        check(config_valid_q, 1'b1);
        ctrl.send_bits(32'h000c_7e95, 20);
        check(config_q, 16'hc7e9);
        $display("test serial done");
    endtask

    task automatic test_crossbar();
        ctrl.send_bits(32'h0000_1000, 16);
        ctrl.step(1, 1'b0);
        check(crossbar_q, 1'b1);
        ctrl.step(1, 1'b1);
        check(crossbar_q, 1'b1);
        ctrl.send_bits(32'h0000_2000, 16);
        ctrl.step(1, 1'b0);
        check(crossbar_q, 1'b0);
        ctrl.step(1, 1'b1);
        check(crossbar_q, 1'b1);
        ctrl.step(1, 1'b1);
        check(crossbar_q, 1'b0);
        $display("test crossbar done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        mismatches = 0;
        check_count = 0;
        test_reset();
        test_pointers();
        test_rows();
        test_holds();
        test_serial();
        test_crossbar();
        test_reset();
        stop_test();
    end

    // whole run takes about 13 us; allow plenty of slack
    initial
    begin
        #300000;
        mismatches++;
        stop_test();
    end
endmodule

// *** rtl/pin_sync.sv ***
// two-flop synchroniser for a vector of quasi-static or slow pin levels
// assumes each bit is sampled independently or held stable while it crosses
`timescale 1ns/1ns
module pin_sync
    import sensor_pkg::*;
#(
    parameter int          WIDTH = 16,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;

    // ----------------------------------------
    // stages
    // ----------------------------------------
    always_comb
    begin
        meta_d   = async_in;
        stable_d = meta_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta_q   <= INIT;
            stable_q <= INIT;
        end
        else
        begin
            meta_q   <= meta_d;
            stable_q <= stable_d;
        end
    end

    assign sync_out = stable_q;

endmodule

// *** rtl/sensor_pin_control.sv ***
// row, column, switchboard and serial configuration logic of the image sensor
// assumes every control pin comes from an external camera controller;
// pin clocks are sampled by ref_clk, the serial clock runs its own domain
//
// Overview of operation
// - reset row pointer steps per its clock edge, loads row 1 on low sync
// - readout row pointer steps per its clock edge, loads row 1 on low sync
// - reset activate high drives reset and select of the reset pointer row while readout activate is low
// - readout activate high drives reset and select of the readout pointer row
// - column pointer shifts per column clock edge, returns to first on low sync
// - switchboard updates on its clock edge, low sync acts on that edge
// - row select high asserts select of the row chosen by the active pointer
// - row reset high resets pixels of the row chosen by the active pointer, whatever row select is
// - reset level hold is 1 to hold, 0 to track
// - signal level hold is 1 to hold, 0 to track
// - serial port shifts one data bit per serial clock rising edge
// - chip select rising edge copies shifted word into configuration register
// - switchboard sync loads crossbar from bit 12, bit 13 toggles it per edge
// - configuration holds CFG_RESET until first written, flagged by config_valid_q
`timescale 1ns/1ns
module sensor_pin_control
    import sensor_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             serial_clock,
    input  wire logic             serial_data,
    input  wire logic             chip_select,
    input  wire logic             reset_pointer_clock,
    input  wire logic             reset_pointer_sync_n,
    input  wire logic             reset_pointer_activate,
    input  wire logic             readout_pointer_clock,
    input  wire logic             readout_pointer_sync_n,
    input  wire logic             readout_pointer_activate,
    input  wire logic             column_clock,
    input  wire logic             column_sync_n,
    input  wire logic             switch_clock,
    input  wire logic             switch_sync_n,
    input  wire logic             row_select,
    input  wire logic             row_reset,
    input  wire logic             reset_level_hold,
    input  wire logic             signal_level_hold,
    input  wire logic             row_init_pulse,
    output logic      [ROW_W-1:0] reset_row_q,
    output logic      [ROW_W-1:0] readout_row_q,
    output logic      [ROW_W-1:0] drive_row_q,
    output logic                  row_select_drive_q,
    output logic                  row_reset_drive_q,
    output logic      [COL_W-1:0] column_pos_q,
    output logic                  crossbar_q,
    output logic                  reset_hold_q,
    output logic                  signal_hold_q,
    output logic                  row_init_q,
    output logic      [CFG_W-1:0] config_q,
    output logic                  config_valid_q
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [ROW_W-1:0] next_row(input logic [ROW_W-1:0] row);
        next_row = (row >= ROW_LAST) ? ROW_FIRST : row + ROW_FIRST;
    endfunction

    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] col);
        next_col = (col >= COL_LAST) ? COL_FIRST : col + COL_FIRST;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [PIN_N-1:0] pin_in;
    logic [PIN_N-1:0] pin_s;
    logic [PIN_N-1:0] pin_prev_q;
    logic [PIN_N-1:0] pin_rise;

    assign pin_in = {chip_select, row_init_pulse, signal_level_hold, reset_level_hold,
                     row_reset, row_select, switch_sync_n, switch_clock,
                     column_sync_n, column_clock, readout_pointer_activate,
                     readout_pointer_sync_n, readout_pointer_clock,
                     reset_pointer_activate, reset_pointer_sync_n, reset_pointer_clock};

    pin_sync #(.WIDTH(PIN_N), .INIT(PIN_RESET)) pins_sync
    (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (pin_in),
        .sync_out (pin_s)
    );

    // edges are found one stage past the synchroniser, never on its first flop
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            pin_prev_q <= PIN_RESET;
        else
            pin_prev_q <= pin_s;
    end

    assign pin_rise = pin_s & ~pin_prev_q;

    // ----------------------------------------
    // serial shifter, serial clock domain
    // ----------------------------------------
    logic [CFG_W-1:0] shift_q;
    logic [CFG_W-1:0] shift_d;

    // lsb arrives first, so it ends at bit 0 after sixteen edges
    always_comb
    begin
        shift_d = {serial_data, shift_q[CFG_W-1:1]};
    end

    // data only; its content is meaningless until a word is shifted in
    always_ff @(posedge serial_clock)
    begin
        shift_q <= shift_d;
    end

    // shifter has no reset; check only once a whole word has landed
    shift_in_a: assert property (@(posedge serial_clock)
        disable iff (!config_valid_q)
        shift_q == {$past(serial_data), $past(shift_q[CFG_W-1:1])})
        else $error("serial shifter lost a bit");

    // the word is quasi-static once the serial clock stops before chip select rises
    logic [CFG_W-1:0] word_s;

    pin_sync #(.WIDTH(CFG_W), .INIT(CFG_RESET)) word_sync
    (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (shift_q),
        .sync_out (word_s)
    );

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    logic [CFG_W-1:0] config_d;
    logic             config_valid_d;

    always_comb
    begin
        config_d       = config_q;
        config_valid_d = config_valid_q;
        if (pin_rise[PIN_CS])
        begin
            config_d       = word_s;
            config_valid_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            config_q       <= CFG_RESET;
            config_valid_q <= 1'b0;
        end
        else
        begin
            config_q       <= config_d;
            config_valid_q <= config_valid_d;
        end
    end

    config_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rise[PIN_CS] |=> config_q == $past(word_s) && config_valid_q)
        else $error("chip select edge did not load configuration");

    // ----------------------------------------
    // row, column and switchboard pointers
    // ----------------------------------------
    logic [ROW_W-1:0] reset_row_d;
    logic [ROW_W-1:0] readout_row_d;
    logic [COL_W-1:0] column_pos_d;
    logic             crossbar_d;

    always_comb
    begin
        reset_row_d   = reset_row_q;
        readout_row_d = readout_row_q;
        column_pos_d  = column_pos_q;
        crossbar_d    = crossbar_q;
        if (pin_rise[PIN_RP_CLK])
            reset_row_d = pin_s[PIN_RP_SYNC] ? next_row(reset_row_q) : ROW_FIRST;
        if (pin_rise[PIN_RO_CLK])
            readout_row_d = pin_s[PIN_RO_SYNC] ? next_row(readout_row_q)
                                               : ROW_FIRST;
        if (pin_rise[PIN_COL_CLK])
            column_pos_d = pin_s[PIN_COL_SYNC] ? next_col(column_pos_q)
                                               : COL_FIRST;
        if (pin_rise[PIN_SW_CLK])
        begin
            if (!pin_s[PIN_SW_SYNC])
                crossbar_d = config_q[CFG_XBAR_INI];
            else if (config_q[CFG_XBAR_TGL])
                crossbar_d = ~crossbar_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            reset_row_q   <= ROW_FIRST;
            readout_row_q <= ROW_FIRST;
            column_pos_q  <= COL_FIRST;
            crossbar_q    <= 1'b0;
        end
        else
        begin
            reset_row_q   <= reset_row_d;
            readout_row_q <= readout_row_d;
            column_pos_q  <= column_pos_d;
            crossbar_q    <= crossbar_d;
        end
    end

    reset_ptr_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rise[PIN_RP_CLK] && !pin_s[PIN_RP_SYNC] |=> reset_row_q == ROW_FIRST)
        else $error("reset pointer did not load row 1");

    reset_ptr_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rise[PIN_RP_CLK] && pin_s[PIN_RP_SYNC]
        |=> reset_row_q == next_row($past(reset_row_q)))
        else $error("reset pointer did not step");

    reset_ptr_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !pin_rise[PIN_RP_CLK] |=> $stable(reset_row_q))
        else $error("reset pointer moved without a clock edge");

    readout_ptr_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rise[PIN_RO_CLK] && !pin_s[PIN_RO_SYNC] |=> readout_row_q == ROW_FIRST)
        else $error("readout pointer did not load row 1");

    readout_ptr_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rise[PIN_RO_CLK] && pin_s[PIN_RO_SYNC]
        |=> readout_row_q == next_row($past(readout_row_q)))
        else $error("readout pointer did not step");

    column_ptr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rise[PIN_COL_CLK] |=> column_pos_q ==
            ($past(pin_s[PIN_COL_SYNC]) ? next_col($past(column_pos_q)) : COL_FIRST))
        else $error("column pointer wrong after clock edge");

    crossbar_sync_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rise[PIN_SW_CLK] && !pin_s[PIN_SW_SYNC]
        |=> crossbar_q == $past(config_q[CFG_XBAR_INI]))
        else $error("crossbar did not take its initial value");

    crossbar_toggle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_rise[PIN_SW_CLK] && pin_s[PIN_SW_SYNC] |=> crossbar_q ==
            ($past(config_q[CFG_XBAR_TGL]) ? !$past(crossbar_q) : $past(crossbar_q)))
        else $error("crossbar toggle wrong");

    // ----------------------------------------
    // row drivers and track and hold
    // ----------------------------------------
    logic [ROW_W-1:0] drive_row_d;
    logic             row_select_drive_d;
    logic             row_reset_drive_d;
    logic             any_active;

    // both activates high is only legal on a shared row, so readout wins any tie
    always_comb
    begin
        any_active = pin_s[PIN_RP_ACT] | pin_s[PIN_RO_ACT];
        drive_row_d = drive_row_q;
        if (pin_s[PIN_RO_ACT])
            drive_row_d = readout_row_q;
        else if (pin_s[PIN_RP_ACT])
            drive_row_d = reset_row_q;
        row_select_drive_d = any_active & pin_s[PIN_ROW_SEL];
        row_reset_drive_d  = any_active & pin_s[PIN_ROW_RST];
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            drive_row_q        <= ROW_FIRST;
            row_select_drive_q <= 1'b0;
            row_reset_drive_q  <= 1'b0;
            reset_hold_q       <= 1'b0;
            signal_hold_q      <= 1'b0;
            row_init_q         <= 1'b0;
        end
        else
        begin
            drive_row_q        <= drive_row_d;
            row_select_drive_q <= row_select_drive_d;
            row_reset_drive_q  <= row_reset_drive_d;
            reset_hold_q       <= pin_s[PIN_RST_HOLD];
            signal_hold_q      <= pin_s[PIN_SIG_HOLD];
            row_init_q         <= pin_s[PIN_ROW_INIT];
        end
    end

    reset_row_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_s[PIN_RP_ACT] && !pin_s[PIN_RO_ACT] |=> drive_row_q == $past(reset_row_q))
        else $error("reset pointer row not driven");

    readout_row_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_s[PIN_RO_ACT] |=> drive_row_q == $past(readout_row_q))
        else $error("readout pointer row not driven");

    select_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 row_select_drive_q == $past(pin_s[PIN_ROW_SEL] &&
            (pin_s[PIN_RP_ACT] || pin_s[PIN_RO_ACT])))
        else $error("row select line wrong");

    reset_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(pin_s[PIN_RP_ACT] || pin_s[PIN_RO_ACT]) |=> !row_reset_drive_q)
        else $error("row reset driven with no active pointer");

    level_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pin_s[PIN_RST_HOLD] && !pin_s[PIN_SIG_HOLD] |=> reset_hold_q && !signal_hold_q)
        else $error("track and hold levels wrong");

endmodule

// *** rtl/sensor_pkg.sv ***
// constants shared by the sensor pin control logic
// assumes a 100 MHz reference clock and pin-level control from a camera controller
package sensor_pkg;

    // ----------------------------------------
    // array geometry
    // ----------------------------------------
    localparam int          ROW_W     = 13;
    localparam int          COL_W     = 12;
    localparam logic [12:0] ROW_FIRST = 13'h0001;
    localparam logic [12:0] ROW_LAST  = 13'h11e8;   // 4560 active plus 24 extra
    localparam logic [11:0] COL_FIRST = 12'h001;
    localparam logic [11:0] COL_LAST  = 12'hc00;    // 3048 active plus 24 extra

    // ----------------------------------------
    // configuration word
    // ----------------------------------------
    localparam int          CFG_W        = 16;
    localparam int          CFG_XBAR_INI = 12;
    localparam int          CFG_XBAR_TGL = 13;
    localparam logic [15:0] CFG_RESET    = 16'h0000;

    // ----------------------------------------
    // synchronised pin vector layout
    // ----------------------------------------
    localparam int PIN_N        = 16;
    localparam int PIN_RP_CLK   = 0;
    localparam int PIN_RP_SYNC  = 1;
    localparam int PIN_RP_ACT   = 2;
    localparam int PIN_RO_CLK   = 3;
    localparam int PIN_RO_SYNC  = 4;
    localparam int PIN_RO_ACT   = 5;
    localparam int PIN_COL_CLK  = 6;
    localparam int PIN_COL_SYNC = 7;
    localparam int PIN_SW_CLK   = 8;
    localparam int PIN_SW_SYNC  = 9;
    localparam int PIN_ROW_SEL  = 10;
    localparam int PIN_ROW_RST  = 11;
    localparam int PIN_RST_HOLD = 12;
    localparam int PIN_SIG_HOLD = 13;
    localparam int PIN_ROW_INIT = 14;
    localparam int PIN_CS       = 15;
    localparam logic [15:0] PIN_RESET = 16'hffff & 16'h0292;  // sync_n pins idle high

endpackage
